// ===== hw/gtc_pkg.sv
// constants, modes and carrier types shared by the timer control block
package gtc_pkg;
	// register bus shape
	localparam int DATA_W = 16;                  // register width
	localparam int ADDR_W = 2;                   // register index width
	localparam logic [ADDR_W-1:0] CORE_IDX = 2'h0; // core timer control
	localparam logic [ADDR_W-1:0] AUX_IDX  = 2'h1; // auxiliary timer control

	// field positions, same layout in both control registers
	localparam int SEL_LSB   = 0;  // input selection [2:0]
	localparam int MODE_LSB  = 3;  // mode field [5:3]
	localparam int RUN_BIT   = 6;  // run bit
	localparam int UD_BIT    = 7;  // software direction
	localparam int UDE_BIT   = 8;  // external direction enable
	localparam int RC_BIT    = 9;  // remote run select (aux only)
	localparam int FM_BIT    = 11; // fast input mode (core only)
	localparam int EDGE_BIT  = 12; // edge-detect flag
	localparam int CHDIR_BIT = 13; // direction-change flag
	localparam int RDIR_BIT  = 14; // current direction, read only
	localparam int IREN_BIT  = 15; // interrupt enable

	// values after reset and plain read/write bits
	localparam logic [DATA_W-1:0] CTL_RESET    = 16'h0000;
	localparam logic [DATA_W-1:0] CORE_RW_MASK = 16'h8FFF; // bits 15, 11..0
	localparam logic [DATA_W-1:0] AUX_RW_MASK  = 16'h83FF; // bits 15, 9..0

	// prescaler: base shift 3 (x8) slow, 2 (x4) fast, plus the code
	localparam int PRESC_W = 10;               // enough for 1024
	localparam logic [3:0] SLOW_SHIFT = 4'h3;
	localparam logic [3:0] FAST_SHIFT = 4'h2;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 10'h000;

	// input sampling: every 4th clock slow, every 2nd fast
	localparam logic [1:0] SLOW_SAMPLE_MASK = 2'h3;
	localparam logic [1:0] FAST_SAMPLE_MASK = 2'h1;

	// input selection codes for counter and incremental modes
	localparam logic [2:0] SEL_OFF  = 3'h0;
	localparam logic [2:0] SEL_RISE = 3'h1;
	localparam logic [2:0] SEL_FALL = 3'h2;
	localparam logic [2:0] SEL_ANY  = 3'h3;
	localparam logic [2:0] SEL_TL_RISE = 3'h5;
	localparam logic [2:0] SEL_TL_FALL = 3'h6;
	localparam logic [2:0] SEL_TL_ANY  = 3'h7;

	// basic operating modes
	typedef enum logic [2:0] {
		GTC_TIMER     = 3'h0,
		GTC_COUNTER   = 3'h1,
		GTC_GATE_LOW  = 3'h2,
		GTC_GATE_HIGH = 3'h3,
		GTC_RELOAD    = 3'h4,
		GTC_CAPTURE   = 3'h5,
		GTC_INC_ROT   = 3'h6,
		GTC_INC_EDGE  = 3'h7
	} gtc_mode_type;

	// configuration handed to a tick generator
	typedef struct packed {
		gtc_mode_type mode;
		logic [2:0]   sel;
		logic         fast;
		logic         run;
	} gtc_cfg_type;

	// input levels seen by a tick generator
	typedef struct packed {
		logic cnt;   // count / gate input
		logic dir;   // direction input
		logic alt;   // toggle latch of the core timer
	} gtc_lvl_type;
endpackage : gtc_pkg

// ===== hw/gtc_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none
module gtc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	// first stage feeds only the second
	logic [W-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// per-bit two-stage chain
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule : gtc_sync
`default_nettype wire

// ===== hw/gtc_tick_gen.sv
// count tick and edge detection for one timer
`timescale 1ns/1ns
`default_nettype none
module gtc_tick_gen #(
	parameter bit AUX     = 1'b0,
	parameter int PRESC_W = gtc_pkg::PRESC_W
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire gtc_pkg::gtc_cfg_type cfg,
	input  wire logic               sample_en,
	input  wire logic [PRESC_W-1:0] presc_cnt,
	input  wire gtc_pkg::gtc_lvl_type lvl,
	output logic                    tick_q,
	output logic                    edge_hit_q
);
	gtc_pkg::gtc_lvl_type prev_q;   // levels at the last sample
	logic rise_cnt, fall_cnt;       // count input edges
	logic any_dir;                  // direction input edge
	logic rise_alt, fall_alt;       // toggle latch edges
	logic presc_hit;                // prescaler period done
	logic tick_c, edge_c;           // decoded this cycle

	// mask of low prescaler bits; a full shift gives all ones (x1024)
	function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] sel,
		input logic fast);
		logic [3:0] sh;
		sh = {1'b0, sel} + (fast ? gtc_pkg::FAST_SHIFT : gtc_pkg::SLOW_SHIFT);
		presc_mask = ~({PRESC_W{1'b1}} << sh);
	endfunction : presc_mask

	// hold sampled levels; edges need two samples, which caps input rate
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= '0;
		end else if (sample_en) begin
			prev_q <= lvl;
		end
	end

	// edges only count on a sampling cycle
	assign rise_cnt = sample_en & lvl.cnt & ~prev_q.cnt;
	assign fall_cnt = sample_en & ~lvl.cnt & prev_q.cnt;
	assign any_dir  = sample_en & (lvl.dir ^ prev_q.dir);
	assign rise_alt = sample_en & lvl.alt & ~prev_q.alt;
	assign fall_alt = sample_en & ~lvl.alt & prev_q.alt;

	// prescaler picks 4<<n fast or 8<<n slow
	assign presc_hit = ((presc_cnt & presc_mask(cfg.sel, cfg.fast)) ==
		presc_mask(cfg.sel, cfg.fast));

	// mode decode of the input selection
	always_comb begin
		tick_c = 1'b0;
		edge_c = 1'b0;
		case (cfg.mode)
			gtc_pkg::GTC_TIMER: begin
				tick_c = presc_hit;
			end
			gtc_pkg::GTC_GATE_LOW: begin
				tick_c = presc_hit & ~prev_q.cnt;
			end
			gtc_pkg::GTC_GATE_HIGH: begin
				tick_c = presc_hit & prev_q.cnt;
			end
			gtc_pkg::GTC_COUNTER: begin
				if (AUX) begin
					// aux counts the core toggle latch; other codes idle
					case (cfg.sel)
						gtc_pkg::SEL_TL_RISE: edge_c = rise_alt;
						gtc_pkg::SEL_TL_FALL: edge_c = fall_alt;
						gtc_pkg::SEL_TL_ANY:  edge_c = rise_alt | fall_alt;
						default:              edge_c = 1'b0;
					endcase
				end else begin
					case (cfg.sel)
						gtc_pkg::SEL_RISE: edge_c = rise_cnt;
						gtc_pkg::SEL_FALL: edge_c = fall_cnt;
						gtc_pkg::SEL_ANY:  edge_c = rise_cnt | fall_cnt;
						default:           edge_c = 1'b0;
					endcase
				end
				tick_c = edge_c;
			end
			gtc_pkg::GTC_INC_ROT, gtc_pkg::GTC_INC_EDGE: begin
				if (AUX) begin
					edge_c = (cfg.sel == gtc_pkg::SEL_FALL) & any_dir;
				end else begin
					case (cfg.sel)
						gtc_pkg::SEL_RISE: edge_c = rise_cnt | fall_cnt;
						gtc_pkg::SEL_FALL: edge_c = any_dir;
						gtc_pkg::SEL_ANY:  edge_c = rise_cnt | fall_cnt | any_dir;
						default:           edge_c = 1'b0;
					endcase
				end
				tick_c = edge_c;
			end
			default: begin
				// reload, capture and reserved codes do not count here
				tick_c = 1'b0;
				edge_c = 1'b0;
			end
		endcase
	end

	// gate results with run and register them
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q     <= 1'b0;
			edge_hit_q <= 1'b0;
		end else begin
			tick_q     <= cfg.run & tick_c;
			edge_hit_q <= cfg.run & edge_c;
		end
	end
endmodule : gtc_tick_gen
`default_nettype wire

// ===== hw/gtc_top.sv
// control and mode decoding for the core timer and first auxiliary timer
// Notes on behaviour
// - core direction change sets sticky flag bit 13
// - core bit 14 shows current direction
// - core bit 15 enables core flag interrupt
// - timer/gated prescaler 4<<n fast, 8<<n slow
// - core counter mode edges on count input
// - core incremental mode edges on count/direction
// - aux mode field bits 5..3 decode
// - aux selection meaning follows selected mode
// - aux run bit 6 starts and stops
// - aux bit 7 sets direction internally
// - aux bit 8 selects external direction line
// - one shared pin feeds three inputs
// - aux bit 9 takes core run bit
// - aux count edge sets sticky flag 12
// - aux direction change sets sticky flag 13
// - aux bit 14 shows current direction
// - aux bit 15 enables aux flag interrupt
// - core mode field decode, 100/101 reserved
// - fast bit picks input rate f/4 or f/8
// - core count edge sets sticky flag 12
`timescale 1ns/1ns
`default_nettype none
module gtc_top #(
	parameter int PRESC_W = gtc_pkg::PRESC_W
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [gtc_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [gtc_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [gtc_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                        core_count_input,
	input  wire logic                        shared_direction_pin,
	input  wire logic                        aux_count_input,
	input  wire logic                        core_toggle_latch,
	output logic                             core_count_tick,
	output logic                             core_count_down,
	output logic                             core_irq,
	output logic                             aux_count_tick,
	output logic                             aux_count_down,
	output logic                             aux_irq,
	output logic                             aux_reload_mode,
	output logic                             aux_capture_mode,
	output logic                             second_aux_count_input,
	output logic                             core_run_bit,
	output logic                             fast_input_mode
);
	// stored read/write fields of both control registers
	logic [gtc_pkg::DATA_W-1:0] core_ctl_q;
	logic [gtc_pkg::DATA_W-1:0] aux_ctl_q;

	// hardware-set flags and direction state
	logic core_edge_flag_q, core_edge_flag_d;
	logic core_dir_change_flag_q, core_dir_change_flag_d;
	logic core_rotation_direction_q, core_dir_d;
	logic aux_edge_flag_q, aux_edge_flag_d;
	logic aux_dir_change_flag_q, aux_dir_change_flag_d;
	logic aux_rotation_direction_q, aux_dir_d;

	// read data register
	logic [gtc_pkg::DATA_W-1:0] rdata_q, rdata_d;

	// free running prescaler shared by both timers
	logic [PRESC_W-1:0] presc_q;
	logic               sample_en;

	// synchronised pin levels
	logic [2:0] pins_sync;
	logic       core_cnt_s, shared_dir_s, aux_cnt_s;

	// write strobes per register
	logic core_wr, aux_wr;

	// decoded fields
	gtc_pkg::gtc_mode_type core_mode_field, aux_mode_field;
	logic [2:0] core_input_select, aux_input_select;
	logic aux_run_bit, aux_direction_bit, aux_ext_direction_enable;
	logic aux_remote_run_select, core_irq_enable, aux_irq_enable;
	logic core_ud, core_ude, aux_run_eff;

	// tick generator carriers
	gtc_pkg::gtc_cfg_type core_cfg, aux_cfg;
	gtc_pkg::gtc_lvl_type core_lvl, aux_lvl;
	logic core_hit, aux_hit;

	// pins come from outside the clock domain
	gtc_sync #(
		.W(3)
	) u_pin_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({aux_count_input, shared_direction_pin, core_count_input}),
		.sync_out (pins_sync)
	);

	assign core_cnt_s   = pins_sync[0];
	assign shared_dir_s = pins_sync[1];
	assign aux_cnt_s    = pins_sync[2];

	// register write decode
	assign core_wr = reg_wr & (reg_addr == gtc_pkg::CORE_IDX);
	assign aux_wr  = reg_wr & (reg_addr == gtc_pkg::AUX_IDX);

	// core field extraction
	assign core_input_select = core_ctl_q[gtc_pkg::SEL_LSB +: 3];
	assign core_mode_field   = gtc_pkg::gtc_mode_type'(core_ctl_q[gtc_pkg::MODE_LSB +: 3]);
	assign core_run_bit      = core_ctl_q[gtc_pkg::RUN_BIT];
	assign core_ud           = core_ctl_q[gtc_pkg::UD_BIT];
	assign core_ude          = core_ctl_q[gtc_pkg::UDE_BIT];
	assign fast_input_mode   = core_ctl_q[gtc_pkg::FM_BIT];
	assign core_irq_enable   = core_ctl_q[gtc_pkg::IREN_BIT];

	// aux field extraction
	assign aux_input_select         = aux_ctl_q[gtc_pkg::SEL_LSB +: 3];
	assign aux_mode_field           = gtc_pkg::gtc_mode_type'(aux_ctl_q[gtc_pkg::MODE_LSB +: 3]);
	assign aux_run_bit              = aux_ctl_q[gtc_pkg::RUN_BIT];
	assign aux_direction_bit        = aux_ctl_q[gtc_pkg::UD_BIT];
	assign aux_ext_direction_enable = aux_ctl_q[gtc_pkg::UDE_BIT];
	assign aux_remote_run_select    = aux_ctl_q[gtc_pkg::RC_BIT];
	assign aux_irq_enable           = aux_ctl_q[gtc_pkg::IREN_BIT];

	// reload and capture belong to the capture/reload unit
	assign aux_reload_mode  = (aux_mode_field == gtc_pkg::GTC_RELOAD);
	assign aux_capture_mode = (aux_mode_field == gtc_pkg::GTC_CAPTURE);

	// remote select hands aux run over to the core run bit
	assign aux_run_eff = aux_remote_run_select ? core_run_bit : aux_run_bit;

	// direction: external line or software bit
	assign core_dir_d = core_ude ? shared_dir_s : core_ud;
	assign aux_dir_d  = aux_ext_direction_enable ? shared_dir_s : aux_direction_bit;

	// shared pin also reaches the second aux timer
	assign second_aux_count_input = shared_dir_s;

	// prescaler counts every clock
	always_ff @(posedge clk) begin
		if (rst) begin
			presc_q <= gtc_pkg::PRESC_RESET;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// sampling rate sets the highest external input rate
	assign sample_en = fast_input_mode ?
		((presc_q[1:0] & gtc_pkg::FAST_SAMPLE_MASK) == gtc_pkg::FAST_SAMPLE_MASK) :
		((presc_q[1:0] & gtc_pkg::SLOW_SAMPLE_MASK) == gtc_pkg::SLOW_SAMPLE_MASK);

	// core timer carriers
	assign core_cfg.mode = core_mode_field;
	assign core_cfg.sel  = core_input_select;
	assign core_cfg.fast = fast_input_mode;
	assign core_cfg.run  = core_run_bit;
	assign core_lvl.cnt  = core_cnt_s;
	assign core_lvl.dir  = shared_dir_s;
	assign core_lvl.alt  = 1'b0;

	// aux timer carriers; gate level comes from its own count pin
	assign aux_cfg.mode = aux_mode_field;
	assign aux_cfg.sel  = aux_input_select;
	assign aux_cfg.fast = fast_input_mode;
	assign aux_cfg.run  = aux_run_eff;
	assign aux_lvl.cnt  = aux_cnt_s;
	assign aux_lvl.dir  = shared_dir_s;
	assign aux_lvl.alt  = core_toggle_latch;

	// core tick generator
	gtc_tick_gen #(
		.AUX     (1'b0),
		.PRESC_W (PRESC_W)
	) u_core_tick (
		.clk        (clk),
		.rst        (rst),
		.cfg        (core_cfg),
		.sample_en  (sample_en),
		.presc_cnt  (presc_q),
		.lvl        (core_lvl),
		.tick_q     (core_count_tick),
		.edge_hit_q (core_hit)
	);

	// aux tick generator
	gtc_tick_gen #(
		.AUX     (1'b1),
		.PRESC_W (PRESC_W)
	) u_aux_tick (
		.clk        (clk),
		.rst        (rst),
		.cfg        (aux_cfg),
		.sample_en  (sample_en),
		.presc_cnt  (presc_q),
		.lvl        (aux_lvl),
		.tick_q     (aux_count_tick),
		.edge_hit_q (aux_hit)
	);

	// core control fields; read-only and flag bits are masked off
	always_ff @(posedge clk) begin
		if (rst) begin
			core_ctl_q <= gtc_pkg::CTL_RESET;
		end else if (core_wr) begin
			core_ctl_q <= reg_wdata & gtc_pkg::CORE_RW_MASK;
		end
	end

	// aux control fields; bits 11..10 never stored
	always_ff @(posedge clk) begin
		if (rst) begin
			aux_ctl_q <= gtc_pkg::CTL_RESET;
		end else if (aux_wr) begin
			aux_ctl_q <= reg_wdata & gtc_pkg::AUX_RW_MASK;
		end
	end

	// flags: only a written zero clears, and a set in the same cycle wins
	assign core_edge_flag_d = core_hit |
		(core_edge_flag_q & ~(core_wr & ~reg_wdata[gtc_pkg::EDGE_BIT]));
	assign core_dir_change_flag_d = (core_dir_d != core_rotation_direction_q) |
		(core_dir_change_flag_q & ~(core_wr & ~reg_wdata[gtc_pkg::CHDIR_BIT]));
	assign aux_edge_flag_d = aux_hit |
		(aux_edge_flag_q & ~(aux_wr & ~reg_wdata[gtc_pkg::EDGE_BIT]));
	assign aux_dir_change_flag_d = (aux_dir_d != aux_rotation_direction_q) |
		(aux_dir_change_flag_q & ~(aux_wr & ~reg_wdata[gtc_pkg::CHDIR_BIT]));

	// core flags and direction state
	always_ff @(posedge clk) begin
		if (rst) begin
			core_edge_flag_q          <= 1'b0;
			core_dir_change_flag_q    <= 1'b0;
			core_rotation_direction_q <= 1'b0;
		end else begin
			core_edge_flag_q          <= core_edge_flag_d;
			core_dir_change_flag_q    <= core_dir_change_flag_d;
			core_rotation_direction_q <= core_dir_d;
		end
	end

	// aux flags and direction state
	always_ff @(posedge clk) begin
		if (rst) begin
			aux_edge_flag_q          <= 1'b0;
			aux_dir_change_flag_q    <= 1'b0;
			aux_rotation_direction_q <= 1'b0;
		end else begin
			aux_edge_flag_q          <= aux_edge_flag_d;
			aux_dir_change_flag_q    <= aux_dir_change_flag_d;
			aux_rotation_direction_q <= aux_dir_d;
		end
	end

	// direction outputs straight from the state flops
	assign core_count_down = core_rotation_direction_q;
	assign aux_count_down  = aux_rotation_direction_q;

	// interrupt requests from enabled flags
	assign core_irq = core_irq_enable & (core_edge_flag_q | core_dir_change_flag_q);
	assign aux_irq  = aux_irq_enable & (aux_edge_flag_q | aux_dir_change_flag_q);

	// read mux; unmapped indices read zero
	always_comb begin
		rdata_d = '0;
		case (reg_addr)
			gtc_pkg::CORE_IDX: begin
				rdata_d = core_ctl_q;
				rdata_d[gtc_pkg::EDGE_BIT]  = core_edge_flag_q;
				rdata_d[gtc_pkg::CHDIR_BIT] = core_dir_change_flag_q;
				rdata_d[gtc_pkg::RDIR_BIT]  = core_rotation_direction_q;
			end
			gtc_pkg::AUX_IDX: begin
				rdata_d = aux_ctl_q;
				rdata_d[gtc_pkg::EDGE_BIT]  = aux_edge_flag_q;
				rdata_d[gtc_pkg::CHDIR_BIT] = aux_dir_change_flag_q;
				rdata_d[gtc_pkg::RDIR_BIT]  = aux_rotation_direction_q;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;
endmodule : gtc_top
`default_nettype wire

// ===== tb/gtc_properties.sv
// port assertions for the timer control block
`timescale 1ns/1ns
`default_nettype none
module gtc_properties #(
	parameter int PRESC_W = gtc_pkg::PRESC_W
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [gtc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [gtc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [gtc_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                       shared_direction_pin,
	input  wire logic                       core_count_tick,
	input  wire logic                       core_irq,
	input  wire logic                       aux_count_tick,
	input  wire logic                       aux_count_down,
	input  wire logic                       aux_irq,
	input  wire logic                       aux_reload_mode,
	input  wire logic                       aux_capture_mode,
	input  wire logic                       second_aux_count_input,
	input  wire logic                       core_run_bit,
	input  wire logic                       fast_input_mode
);
	logic       core_ien_q; // core irq enable
	logic       aux_ien_q;  // aux irq enable
	logic       aux_dir_q;  // aux sw direction
	logic       aux_ude_q;  // aux ext direction enable
	logic [2:0] aux_age_q;  // cycles since aux write
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence core_wr_s;
		reg_wr && reg_addr == gtc_pkg::CORE_IDX;
	endsequence
	sequence aux_wr_s;
		reg_wr && reg_addr == gtc_pkg::AUX_IDX;
	endsequence
	// mirrors of software bits
	always_ff @(posedge clk) begin
		if (rst) begin
			core_ien_q <= 1'b0;
			aux_ien_q  <= 1'b0;
			aux_dir_q  <= 1'b0;
			aux_ude_q  <= 1'b0;
		end else if (reg_wr && reg_addr == gtc_pkg::CORE_IDX) begin
			core_ien_q <= reg_wdata[gtc_pkg::IREN_BIT];
		end else if (reg_wr && reg_addr == gtc_pkg::AUX_IDX) begin
			aux_ien_q <= reg_wdata[gtc_pkg::IREN_BIT];
			aux_dir_q <= reg_wdata[gtc_pkg::UD_BIT];
			aux_ude_q <= reg_wdata[gtc_pkg::UDE_BIT];
		end
	end
	// settling time after an aux write
	always_ff @(posedge clk) begin
		if (rst || (reg_wr && reg_addr == gtc_pkg::AUX_IDX)) begin
			aux_age_q <= 3'h0;
		end else if (aux_age_q != 3'h7) begin
			aux_age_q <= aux_age_q + 3'h1;
		end
	end
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("stale read data");
	core_irq_off_a: assert property (core_wr_s ##0 !reg_wdata[15] |=> !core_irq)
		else $error("core irq unmasked");
	aux_irq_off_a: assert property (aux_wr_s ##0 !reg_wdata[15] |=> !aux_irq)
		else $error("aux irq unmasked");
	core_flag_irq_a: assert property (
		core_count_tick && core_ien_q && !reg_wr |-> ##[0:1] core_irq)
		else $error("core irq missing");
	aux_flag_irq_a: assert property (
		aux_count_tick && aux_ien_q && !reg_wr |-> ##[0:1] aux_irq)
		else $error("aux irq missing");
	core_cfg_out_a: assert property (core_wr_s |=>
		core_run_bit == $past(reg_wdata[6]) && fast_input_mode == $past(reg_wdata[11]))
		else $error("core cfg outputs");
	aux_mode_dec_a: assert property (aux_wr_s |=>
		aux_reload_mode == ($past(reg_wdata[5:3]) == gtc_pkg::GTC_RELOAD) &&
		aux_capture_mode == ($past(reg_wdata[5:3]) == gtc_pkg::GTC_CAPTURE))
		else $error("aux mode decode");
	unmapped_wr_a: assert property (reg_wr && reg_addr[1] |=>
		$stable(core_run_bit) && $stable(fast_input_mode) && $stable(aux_reload_mode))
		else $error("unmapped write");
	shared_pin_a: assert property (
		second_aux_count_input == $past(shared_direction_pin, 2))
		else $error("shared pin path");
	tick_pulse_a: assert property (core_count_tick |=> !core_count_tick)
		else $error("long core tick");
	aux_sw_dir_a: assert property (
		aux_age_q == 3'h7 && !aux_ude_q |-> aux_count_down == aux_dir_q)
		else $error("aux sw direction");
endmodule : gtc_properties
bind gtc_top gtc_properties #(.PRESC_W(PRESC_W)) chk_u (.*);
`default_nettype wire

// ===== tb/gtc_pin_model.sv
// model of the external count, direction and gate pins
`timescale 1ns/1ns
`default_nettype none
module gtc_pin_model (
	input  wire logic clk,      // timer clock
	output var  logic cnt_pin,  // core count input level
	output var  logic dir_pin,  // shared direction line
	output var  logic gate_pin  // aux gate level
);
	// pins idle low
	initial begin
		cnt_pin  = 1'b0;
		dir_pin  = 1'b0;
		gate_pin = 1'b0;
	end
	// new levels just after an edge, then held
	task automatic drive(input logic [2:0] lv, input int hold);
		@(posedge clk);
		{gate_pin, dir_pin, cnt_pin} <= lv;
		repeat (hold) @(posedge clk);
	endtask : drive
endmodule : gtc_pin_model
`default_nettype wire

// ===== tb/tb.sv
// bench for the timer control block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk, rst;                 // 100 MHz clock, sync reset
	logic [1:0]  reg_addr;                 // register bus
	logic [15:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd;
	logic        cnt_pin, dir_pin, gate_pin; // pins from the model
	logic        core_tick, core_down, core_irq, aux_tick, aux_down, aux_irq;
	logic        aux_reload, aux_capture, sec_in, core_run, fast_mode;
	int          fail_count, tests_run, ctk, atk; // tick tallies
	gtc_top #(.PRESC_W(gtc_pkg::PRESC_W)) dut_u (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.core_count_input(cnt_pin), .shared_direction_pin(dir_pin),
		.aux_count_input(gate_pin), .core_toggle_latch(1'b0),
		.core_count_tick(core_tick), .core_count_down(core_down), .core_irq(core_irq),
		.aux_count_tick(aux_tick), .aux_count_down(aux_down), .aux_irq(aux_irq),
		.aux_reload_mode(aux_reload), .aux_capture_mode(aux_capture),
		.second_aux_count_input(sec_in), .core_run_bit(core_run),
		.fast_input_mode(fast_mode));
	gtc_pin_model pins_u (.clk(clk), .cnt_pin(cnt_pin), .dir_pin(dir_pin), .gate_pin(gate_pin));
	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// tick tallies
	always @(posedge clk) begin
		if (core_tick === 1'b1) ctk++;
		if (aux_tick === 1'b1) atk++;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [1:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask : rchk
	// clocks between core ticks, bounded
	task automatic gap(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (core_tick !== 1'b1 && n < 2000);
	endtask : gap
	task automatic t_regs;
		rchk("core reset", gtc_pkg::CORE_IDX, 16'h0000);
		rchk("aux reset", gtc_pkg::AUX_IDX, 16'h0000);
		wr(2'h2, 16'hFFFF);
		wr(2'h3, 16'hFFFF);
		rchk("core unmapped", gtc_pkg::CORE_IDX, 16'h0000);
		rchk("unmapped read", 2'h3, 16'h0000);
		wr(gtc_pkg::AUX_IDX, 16'hFFFF);
		rchk("aux reserved", gtc_pkg::AUX_IDX, 16'h83FF);
		wr(gtc_pkg::CORE_IDX, 16'hFFFF);
		rchk("core bits", gtc_pkg::CORE_IDX, 16'h8FFF);
		chk("fast out", 16'h0001, {15'h0, fast_mode});
		wr(gtc_pkg::CORE_IDX, 16'h0000);
		wr(gtc_pkg::AUX_IDX, 16'h0000);
	endtask : t_regs
	// table {mode, sel, core ticks}; aux counts direction pin edges
	task automatic t_edges;
		logic [8:0]  tab [10];
		logic [15:0] cfg;
		tab = '{9'h040, 9'h049, 9'h051, 9'h05A, 9'h060,
			9'h1C0, 9'h1CA, 9'h1D2, 9'h1DC, 9'h1E8};
		foreach (tab[i]) begin
			cfg = 16'h8040 | {10'h000, tab[i][8:3]};
			wr(gtc_pkg::CORE_IDX, cfg);
			wr(gtc_pkg::AUX_IDX, 16'h8072);
			ctk = 0;
			atk = 0;
			pins_u.drive(3'h1, 12);
			pins_u.drive(3'h0, 12);
			pins_u.drive(3'h2, 12);
			pins_u.drive(3'h0, 12);
			chk("core ticks", {13'h0, tab[i][2:0]}, 16'(ctk));
			chk("aux ticks", 16'h0002, 16'(atk));
			rchk("core flag", gtc_pkg::CORE_IDX, cfg | {3'h0, tab[i][2:0] != 3'h0, 12'h0});
			chk("irqs", {14'h0, tab[i][2:0] != 3'h0, 1'b1}, {14'h0, core_irq, aux_irq});
			rchk("aux flag", gtc_pkg::AUX_IDX, 16'h9072);
			wr(gtc_pkg::CORE_IDX, 16'h0000);
			wr(gtc_pkg::AUX_IDX, 16'h0000);
		end
	endtask : t_edges
	// prescaler periods, longest code too
	task automatic t_timer;
		logic [15:0] cfg [5];
		int          per [5];
		int          n;
		cfg = '{16'h0840, 16'h0040, 16'h0843, 16'h0047, 16'h0847};
		per = '{4, 8, 32, 1024, 512};
		foreach (cfg[i]) begin
			wr(gtc_pkg::CORE_IDX, cfg[i]);
			gap(n);
			gap(n);
			chk("tick period", 16'(per[i]), 16'(n));
		end
		wr(gtc_pkg::CORE_IDX, 16'h0000);
	endtask : t_timer
	// own run bit against remote run
	task automatic t_remote;
		logic [15:0] cv [4];
		logic [15:0] av [4];
		logic [3:0]  ex;
		cv = '{16'h0000, 16'h0040, 16'h0000, 16'h0040};
		av = '{16'h0200, 16'h0200, 16'h0040, 16'h0000};
		ex = 4'h6;
		foreach (cv[i]) begin
			wr(gtc_pkg::CORE_IDX, cv[i]);
			wr(gtc_pkg::AUX_IDX, av[i]);
			cyc(4);
			atk = 0;
			cyc(40);
			chk("aux running", {15'h0, ex[i]}, {15'h0, atk != 0});
		end
		for (int m = 0; m < 8; m++) begin
			wr(gtc_pkg::AUX_IDX, 16'(m) << 3);
			cyc(1);
			chk("mode decode", {14'h0, m == 4, m == 5}, {14'h0, aux_reload, aux_capture});
		end
		wr(gtc_pkg::CORE_IDX, 16'h0000);
		wr(gtc_pkg::AUX_IDX, 16'h0000);
	endtask : t_remote
	// direction sources, change flags, irq mask
	task automatic t_dir;
		wr(gtc_pkg::AUX_IDX, 16'h0080);
		cyc(6);
		rchk("aux sw down", gtc_pkg::AUX_IDX, 16'h6080);
		wr(gtc_pkg::AUX_IDX, 16'h0180);
		cyc(6);
		rchk("aux ext up", gtc_pkg::AUX_IDX, 16'h2180);
		wr(gtc_pkg::CORE_IDX, 16'h0100);
		pins_u.drive(3'h2, 10);
		rchk("core ext down", gtc_pkg::CORE_IDX, 16'h6100);
		chk("down outs", 16'h0003, {14'h0, core_down, aux_down});
		wr(gtc_pkg::AUX_IDX, 16'h0180);
		cyc(2);
		rchk("aux flag clear", gtc_pkg::AUX_IDX, 16'h4180);
		chk("core irq masked", 16'h0000, {15'h0, core_irq});
		wr(gtc_pkg::CORE_IDX, 16'hA100);
		cyc(1);
		chk("core irq on", 16'h0001, {15'h0, core_irq});
		pins_u.drive(3'h0, 10);
		wr(gtc_pkg::CORE_IDX, 16'h0000);
		wr(gtc_pkg::AUX_IDX, 16'h0000);
	endtask : t_dir
	task automatic summarize;
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	// reset four cycles, then scenarios
	initial begin
		rst        = 1'b1;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		reg_addr   = 2'h0;
		reg_wdata  = 16'h0000;
		fail_count = 0;
		tests_run  = 0;
		ctk        = 0;
		atk        = 0;
		cyc(4);
		rst <= 1'b0;
		t_regs;
		t_edges;
		t_timer;
		t_remote;
		t_dir;
		summarize;
	end
	// watchdog, well past the run
	initial begin
		#500000;
		fail_count++;
		summarize;
	end
endmodule : tb
`default_nettype wire
